// ==== design/temp_conv_core.sv ====
// temperature conversion core with thermostat and wishbone registers
`timescale 1ns/1ns
`include "temp_conv_map.svh"
module temp_conv_core #(
	parameter int unsigned CONV_LIMIT = `CONV_LIMIT_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic count_osc_i,
	input wire logic gate_osc_i,
	output logic thermostat_output_o
);
	temp_conv_pkg::core_state_type s_reg;
	temp_conv_pkg::core_state_type s_next;
	logic count_rise;
	logic gate_rise;
	logic dec_active;
	logic dec_high;
	logic dec_low;
	logic [8:0] temp_next;

	pin_sync count_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(count_osc_i),
		.rise_o(count_rise)
	);

	pin_sync gate_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(gate_osc_i),
		.rise_o(gate_rise)
	);

	// temperature after any step that lands in this cycle
	always_comb begin
		temp_next = s_reg.temp_work;
		if (s_reg.state == temp_conv_pkg::convert_state && count_rise
				&& s_reg.gate_count <= 16'h0001
				&& s_reg.temp_work != `TEMP_MAX) begin
			temp_next = 9'(s_reg.temp_work + 9'h001);
		end
	end

	thermostat_decide decide (
		.temp_i(temp_next),
		.high_trip_i(s_reg.high_trip),
		.low_trip_i(s_reg.low_trip),
		.active_i(s_reg.active),
		.active_o(dec_active),
		.high_hit_o(dec_high),
		.low_hit_o(dec_low)
	);

	function automatic logic [31:0] read_mux(input temp_conv_pkg::core_state_type s,
			input logic [7:0] adr);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (adr == `TEMP_ADDR) begin
			// upper byte whole degrees, lower byte half bit on top
			v[15:0] = {s.temp_result[8:1], s.temp_result[0], 7'h00};
		end else if (adr == `HIGH_TRIP_ADDR) begin
			v[15:0] = {s.high_trip[8:1], s.high_trip[0], 7'h00};
		end else if (adr == `LOW_TRIP_ADDR) begin
			v[15:0] = {s.low_trip[8:1], s.low_trip[0], 7'h00};
		end else if (adr == `CONFIG_ADDR) begin
			v[`CFG_DONE_BIT] = s.done;
			v[`CFG_HIGH_SEEN_BIT] = s.high_seen;
			v[`CFG_LOW_SEEN_BIT] = s.low_seen;
			v[`CFG_NV_BUSY_BIT] = 1'b0;
			v[`CFG_ONE_BIT] = 1'b1;
			v[`CFG_POL_BIT] = s.output_polarity_bit;
			v[`CFG_SINGLE_BIT] = s.single;
		end else if (adr == `COUNT_ADDR) begin
			v[15:0] = s.count_value;
		end else if (adr == `SLOPE_BASE_ADDR) begin
			v[15:0] = s.slope_base;
		end else if (adr == `SLOPE_STEP_ADDR) begin
			v[7:0] = s.slope_step;
		end
		return v;
	endfunction

	always_comb begin
		logic req;
		logic wr;
		logic close_gate;
		logic start_now;
		req = 1'b0;
		wr = 1'b0;
		close_gate = 1'b0;
		start_now = 1'b0;
		s_next = s_reg;
		req = wb_cyc_i && wb_stb_i && !s_reg.ack;
		wr = req && wb_we_i && wb_sel_i[0];
		s_next.ack = req;
		if (req) begin
			s_next.rdata = read_mux(s_reg, wb_adr_i);
		end

		// register writes; thresholds and settings take the low 16 bits
		if (wr && wb_sel_i[1]) begin
			if (wb_adr_i == `HIGH_TRIP_ADDR) begin
				s_next.high_trip = {wb_dat_i[15:8], wb_dat_i[7]};
			end else if (wb_adr_i == `LOW_TRIP_ADDR) begin
				s_next.low_trip = {wb_dat_i[15:8], wb_dat_i[7]};
			end else if (wb_adr_i == `SLOPE_BASE_ADDR) begin
				s_next.slope_base = wb_dat_i[15:0];
			end
		end
		if (wr) begin
			if (wb_adr_i == `CONFIG_ADDR) begin
				s_next.output_polarity_bit = wb_dat_i[`CFG_POL_BIT];
				s_next.single = wb_dat_i[`CFG_SINGLE_BIT];
				if (!wb_dat_i[`CFG_HIGH_SEEN_BIT]) begin
					s_next.high_seen = 1'b0;
				end
				if (!wb_dat_i[`CFG_LOW_SEEN_BIT]) begin
					s_next.low_seen = 1'b0;
				end
			end else if (wb_adr_i == `SLOPE_STEP_ADDR) begin
				s_next.slope_step = wb_dat_i[7:0];
			end else if (wb_adr_i == `COMMAND_ADDR) begin
				if (wb_dat_i[`CMD_START_BIT]) begin
					s_next.start_pending = 1'b1;
				end
				if (wb_dat_i[`CMD_STOP_BIT]) begin
					s_next.start_pending = 1'b0;
				end
				if (wb_dat_i[`CMD_SLOPE_BIT]) begin
					s_next.count_value = s_reg.slope_acc;
				end
			end
		end

		case (s_reg.state)
			temp_conv_pkg::idle_state: begin
				// continuous mode restarts by itself, one-shot waits for a command
				start_now = s_reg.start_pending;
			end
			temp_conv_pkg::convert_state: begin
				s_next.limit_timer = 25'(s_reg.limit_timer + 25'h000_0001);
				if (count_rise) begin
					s_next.temp_work = temp_next;
					if (s_reg.gate_count <= 16'h0001) begin
						s_next.gate_count = s_reg.slope_acc;
						// widen the step after next so the parabola is followed
						s_next.slope_acc = 16'(s_reg.slope_acc + {8'h00, s_reg.slope_step});
					end else begin
						s_next.gate_count = 16'(s_reg.gate_count - 16'h0001);
					end
				end
				if (gate_rise) begin
					s_next.gate_edges = 16'(s_reg.gate_edges + 16'h0001);
				end
				// a stalled gate oscillator cannot hold the result past the limit
				if ((gate_rise && s_reg.gate_edges == 16'(`GATE_EDGES - 16'h0001))
						|| s_reg.limit_timer >= 25'(CONV_LIMIT - 1)) begin
					close_gate = 1'b1;
				end
			end
			default: begin
				s_next.state = temp_conv_pkg::idle_state;
			end
		endcase

		if (close_gate) begin
			s_next.temp_result = temp_next;
			s_next.count_value = count_rise && s_reg.gate_count <= 16'h0001
				? s_reg.slope_acc : s_next.gate_count;
			s_next.done = 1'b1;
			s_next.active = dec_active;
			if (dec_high) begin
				s_next.high_seen = 1'b1;
			end
			if (dec_low) begin
				s_next.low_seen = 1'b1;
			end
			if (s_reg.single) begin
				s_next.start_pending = 1'b0;
			end
			s_next.state = temp_conv_pkg::idle_state;
		end

		if (start_now) begin
			s_next.state = temp_conv_pkg::convert_state;
			s_next.gate_count = `BASE_COUNT;
			s_next.temp_work = `TEMP_MIN;
			s_next.slope_acc = s_reg.slope_base;
			s_next.gate_edges = 16'h0000;
			s_next.limit_timer = 25'h000_0000;
			s_next.done = 1'b0;
		end

		if (!s_reg.single && s_next.state == temp_conv_pkg::idle_state) begin
			s_next.start_pending = 1'b1;
		end
		s_next.thermostat = s_next.output_polarity_bit ? s_next.active : !s_next.active;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.state <= temp_conv_pkg::idle_state;
			s_reg.temp_work <= `TEMP_MIN;
			s_reg.temp_result <= `TEMP_MIN;
			s_reg.high_trip <= `HIGH_TRIP_RESET;
			s_reg.low_trip <= `LOW_TRIP_RESET;
			s_reg.output_polarity_bit <= `POL_RESET;
			s_reg.single <= `SINGLE_RESET;
			s_reg.slope_base <= `SLOPE_BASE_RESET;
			s_reg.slope_step <= `SLOPE_STEP_RESET;
			s_reg.thermostat <= !`POL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.rdata;
	assign thermostat_output_o = s_reg.thermostat;
endmodule // temp_conv_core

// ==== design/temp_conv_map.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef TEMP_CONV_MAP_SVH
`define TEMP_CONV_MAP_SVH

`define TEMP_ADDR 8'h00
`define HIGH_TRIP_ADDR 8'h04
`define LOW_TRIP_ADDR 8'h08
`define CONFIG_ADDR 8'h0C
`define COUNT_ADDR 8'h10
`define COMMAND_ADDR 8'h14
`define SLOPE_BASE_ADDR 8'h18
`define SLOPE_STEP_ADDR 8'h1C

`define CFG_DONE_BIT 7
`define CFG_HIGH_SEEN_BIT 6
`define CFG_LOW_SEEN_BIT 5
`define CFG_NV_BUSY_BIT 4
`define CFG_ONE_BIT 3
`define CFG_POL_BIT 1
`define CFG_SINGLE_BIT 0

`define CMD_START_BIT 0
`define CMD_STOP_BIT 1
`define CMD_SLOPE_BIT 2

`define TEMP_MIN 9'h192
`define TEMP_MAX 9'h0FA
`define HIGH_TRIP_RESET 9'h0FA
`define LOW_TRIP_RESET 9'h192
`define POL_RESET 1'b1
`define SINGLE_RESET 1'b0
`define BASE_COUNT 16'h0100
`define SLOPE_BASE_RESET 16'h0040
`define SLOPE_STEP_RESET 8'h01
`define GATE_EDGES 16'h0800

`define CLK_HZ 25000000
`define CONV_LIMIT_MS 1000
`define CONV_LIMIT_CYCLES ((`CLK_HZ / 1000) * `CONV_LIMIT_MS)

`endif

// ==== design/temp_conv_pkg.sv ====
// types shared by the conversion core
package temp_conv_pkg;

	typedef enum logic [0:0] {
		idle_state,
		convert_state
	} conv_state_type;

	typedef struct packed {
		conv_state_type state;
		logic [15:0] gate_count;
		logic [15:0] slope_acc;
		logic [15:0] gate_edges;
		logic [24:0] limit_timer;
		logic [8:0] temp_work;
		logic [8:0] temp_result;
		logic [15:0] count_value;
		logic [8:0] high_trip;
		logic [8:0] low_trip;
		logic output_polarity_bit;
		logic single;
		logic done;
		logic high_seen;
		logic low_seen;
		logic active;
		logic start_pending;
		logic [15:0] slope_base;
		logic [7:0] slope_step;
		logic ack;
		logic [31:0] rdata;
		logic thermostat;
	} core_state_type;

endpackage

// ==== design/pin_sync.sv ====
// two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ns
module pin_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic rise_o
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// only sync_reg reads meta_reg; the edge detector looks one stage later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign rise_o = sync_reg & ~last_reg;
endmodule // pin_sync

// ==== design/thermostat_decide.sv ====
// hysteresis decision made at the end of a conversion
`timescale 1ns/1ns
module thermostat_decide (
	input wire logic [8:0] temp_i,
	input wire logic [8:0] high_trip_i,
	input wire logic [8:0] low_trip_i,
	input wire logic active_i,
	output logic active_o,
	output logic high_hit_o,
	output logic low_hit_o
);
	always_comb begin
		high_hit_o = $signed(temp_i) >= $signed(high_trip_i);
		low_hit_o = $signed(temp_i) <= $signed(low_trip_i);
		if (high_hit_o) begin
			active_o = 1'b1;
		end else if ($signed(temp_i) < $signed(low_trip_i)) begin
			active_o = 1'b0;
		end else begin
			active_o = active_i;
		end
	end
endmodule // thermostat_decide

// ==== verif/temp_conv_properties.sv ====
// port-level assertions for the conversion core
`timescale 1ns/1ns
`include "temp_conv_map.svh"
module temp_conv_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic thermostat_output_o
);
	wire logic rd_ack = wb_ack_o && !wb_we_i;
	wire logic signed [8:0] rd_temp = wb_dat_o[15:7];
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property read_of(adr, ok);
		rd_ack && wb_adr_i == adr |-> ok;
	endproperty
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !thermostat_output_o)
		else $error("outputs active after reset");
	chk_temp_half: assert property (read_of(`TEMP_ADDR, wb_dat_o[6:0] == 7'h00))
		else $error("temperature low bits not zero");
	chk_temp_upper: assert property (read_of(`TEMP_ADDR, wb_dat_o[31:16] == 16'h0000))
		else $error("temperature upper bits not zero");
	chk_temp_span: assert property (read_of(`TEMP_ADDR, rd_temp >= $signed(`TEMP_MIN)))
		else $error("temperature below span");
	chk_cfg_fixed: assert property (read_of(`CONFIG_ADDR, wb_dat_o[4:2] == 3'b010))
		else $error("config fixed bits wrong");
	chk_unmapped_zero: assert property (rd_ack && wb_adr_i > `SLOPE_STEP_ADDR |-> !wb_dat_o)
		else $error("unmapped read not zero");
	cover property (rd_ack && wb_adr_i == `TEMP_ADDR);
	cover property ($rose(thermostat_output_o));
	cover property ($fell(thermostat_output_o));
endmodule // temp_conv_properties

// ==== verif/osc_pair_model.sv ====
// free-running counted and gate oscillators
`timescale 1ns/1ns
module osc_pair_model #(
	parameter int COUNT_HALF = 160,
	parameter int GATE_HALF = 1700
) (
	input wire logic slow_i,
	output logic count_osc_o,
	output logic gate_osc_o
);
	// real oscillators never stop, so no idle level between conversions
	initial begin
		count_osc_o = 1'b0;
		gate_osc_o = 1'b0;
	end
	always begin
		#(slow_i ? 2 * COUNT_HALF : COUNT_HALF);
		count_osc_o = !count_osc_o;
	end
	always #(GATE_HALF) gate_osc_o = !gate_osc_o;
endmodule // osc_pair_model

// ==== verif/test_temp_conv_thermostat.sv ====
// self-checking bench for the conversion core
`timescale 1ns/1ns
`include "temp_conv_map.svh"
module test_temp_conv_thermostat;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic count_osc_i;
	logic gate_osc_i;
	logic thermostat_output_o;
	logic slow = 1'b0;
	logic [31:0] rd_data;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [31:0] hi_t[4] = '{32'h0000_C900, 32'h0000_7D00, 32'h0000_7D00, 32'h0000_C900};
	logic [31:0] lo_t[4] = '{32'h0000_C900, 32'h0000_C900, 32'h0000_7D00, 32'h0000_C900};
	logic [31:0] t_t[4] = '{32'h0000_CB00, 32'h0000_CB00, 32'h0000_C900, 32'h0000_CB00};
	logic [3:0] pol_t = 4'h7;
	logic [3:0] slow_t = 4'h4;
	logic [3:0] pre_t = 4'hE;
	logic [3:0] pin_t = 4'h3;
	logic [3:0] hs_t = 4'h9;
	int err_total = 0;
	int compares = 0;
	int seed = 32'h0000_8000;
	always #20 clk_i = !clk_i;
	temp_conv_core #(.CONV_LIMIT(4000)) temp_conv_core_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.count_osc_i(count_osc_i), .gate_osc_i(gate_osc_i),
		.thermostat_output_o(thermostat_output_o));
	osc_pair_model osc_pair_model_inst (.slow_i(slow), .count_osc_o(count_osc_i),
		.gate_osc_o(gate_osc_i));
	task automatic final_report();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
			input logic [31:0] msk);
		int n = 0;
		if (!we) begin
			exp_q.push_back(dat);
			msk_q.push_back(msk);
		end
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd_data = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			err_total++;
			final_report();
		end
		@(posedge clk_i);
	endtask
	task automatic wait_done();
		int k = 0;
		do begin
			bus(1'b0, `CONFIG_ADDR, 32'h0000_0000, 32'h0000_0000);
			k++;
		end while (rd_data[7] !== 1'b1 && k < 3000);
		if (k >= 3000) begin
			err_total++;
			final_report();
		end
	endtask
	// reads are judged here so the driver never waits on a comparison
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
			if (msk_q[0] !== 32'h0000_0000) cmp("read data", exp_q[0] & msk_q[0],
				wb_dat_o & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b0, `TEMP_ADDR, 32'h0000_C900, 32'hFFFF_FFFF);
		bus(1'b0, `HIGH_TRIP_ADDR, 32'h0000_7D00, 32'hFFFF_FFFF);
		bus(1'b0, `LOW_TRIP_ADDR, 32'h0000_C900, 32'hFFFF_FFFF);
		bus(1'b0, `CONFIG_ADDR, 32'h0000_000A, 32'hFFFF_FFFF);
		bus(1'b1, `CONFIG_ADDR, 32'h0000_0003, 32'h0000_0000);
		wait_done();
		for (int i = 0; i < 4; i++) begin
			slow <= slow_t[i];
			bus(1'b1, `HIGH_TRIP_ADDR, hi_t[i], 32'h0000_0000);
			bus(1'b1, `LOW_TRIP_ADDR, lo_t[i], 32'h0000_0000);
			bus(1'b1, `CONFIG_ADDR, {30'h0000_0000, pol_t[i], 1'b1}, 32'h0000_0000);
			cmp("pin before start", {31'h0000_0000, pre_t[i]}, {31'h0000_0000, thermostat_output_o});
			bus(1'b1, `COMMAND_ADDR, 32'h0000_0001, 32'h0000_0000);
			wait_done();
			cmp("pin after done", {31'h0000_0000, pin_t[i]}, {31'h0000_0000, thermostat_output_o});
			bus(1'b0, `TEMP_ADDR, t_t[i], 32'hFFFF_FFFF);
			bus(1'b0, `CONFIG_ADDR, {25'h000_0000, hs_t[i], 6'h00}, 32'h0000_0040);
		end
		bus(1'b1, `COMMAND_ADDR, 32'h0000_0004, 32'h0000_0000);
		bus(1'b0, `COUNT_ADDR, 32'h0000_0044, 32'h0000_FFFF);
		bus(1'b1, 8'h20, $random(seed), 32'h0000_0000);
		bus(1'b0, 8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
		final_report();
	end
endmodule // test_temp_conv_thermostat
bind temp_conv_core temp_conv_properties temp_conv_properties_inst (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.thermostat_output_o(thermostat_output_o));
